// ===== include/ftx_pkg.sv
package ftx_pkg;
	// ****************************************
	// timing
	// ****************************************
	localparam int unsigned CLK_SYS_HZ = 50_000_000;
	localparam int unsigned INT_CLK_HZ = 25_000_000;
	localparam int unsigned LINE_BPS   = 125_000_000;
	localparam int unsigned SYM_BITS   = LINE_BPS / INT_CLK_HZ;
	localparam int unsigned NIB_BITS   = 4;
	localparam int unsigned FIFO_W     = NIB_BITS + 1;
	localparam int unsigned FIFO_DEPTH = 8;
	localparam logic [2:0]  BIT_CNT_RST  = 3'h0;
	localparam logic [2:0]  BIT_CNT_LAST = 3'(SYM_BITS - 1);
	localparam logic [2:0]  STB_PHASE    = 3'h2;
	// ****************************************
	// scrambler and line levels
	// ****************************************
	localparam int unsigned SCR_LEN   = 11;
	localparam int unsigned SCR_TAP_A = 10;
	localparam int unsigned SCR_TAP_B = 8;
	localparam logic [10:0] SCR_SEED  = 11'h7FF;
	localparam logic [1:0]  MLT_NEG   = 2'h0;
	localparam logic [1:0]  MLT_ZUP   = 2'h1;
	localparam logic [1:0]  MLT_POS   = 2'h2;
	localparam logic [1:0]  MLT_RST   = 2'h1;
	// ****************************************
	// code groups
	// ****************************************
	typedef logic [4:0] ftx_code_type;
	localparam ftx_code_type CODE_I  = 5'h1F;
	localparam ftx_code_type CODE_J  = 5'h18;
	localparam ftx_code_type CODE_K  = 5'h11;
	localparam ftx_code_type CODE_T  = 5'h0D;
	localparam ftx_code_type CODE_R  = 5'h07;
	localparam ftx_code_type CODE_FC = 5'h10;
	typedef enum logic [1:0] {ST_IDLE, ST_K, ST_DATA, ST_R} ftx_state_type;
	localparam ftx_code_type ENC_TABLE [16] = '{
		5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
		5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};

	function automatic ftx_code_type enc_4b5b(input logic [3:0] nib);
		return ENC_TABLE[nib];
	endfunction

	function automatic logic code_legal(input ftx_code_type c);
		logic hit;
		hit = (c == CODE_I) || (c == CODE_J) || (c == CODE_K) || (c == CODE_T) || (c == CODE_R);
		for (int i = 0; i < 16; i++) begin
			hit = hit || (c == ENC_TABLE[i]);
		end
		return hit;
	endfunction
endpackage

// ===== include/ftx_stream_if.sv
`timescale 1ns/10ps
interface ftx_stream_if #(parameter int unsigned WIDTH = 5);
	logic             valid;
	logic             ready;
	logic [WIDTH-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

// ===== rtl/ftx_fifo.sv
`timescale 1ns/10ps
module ftx_fifo #(
	parameter int unsigned WIDTH = 5,
	parameter int unsigned DEPTH = 8
) (
	input  wire logic   clk_sys,
	input  wire logic   rst,
	ftx_stream_if.snk   in_s,
	ftx_stream_if.src   out_s
);
	localparam int unsigned AW = $clog2(DEPTH);

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad
		$error("fifo depth must be a power of two of at least 2");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW:0]      count_reg;
	logic [AW:0]      count_next;
	logic             not_full_reg;
	logic             not_empty_reg;
	logic             push;
	logic             pop;

	// flags are registers so the mac-facing ready has no logic after it
	assign push        = in_s.valid && not_full_reg;
	assign pop         = out_s.ready && not_empty_reg;
	assign in_s.ready  = not_full_reg;
	assign out_s.valid = not_empty_reg;
	assign out_s.data  = mem[rd_ptr_reg];
	assign count_next  = count_reg + (AW + 1)'(push) - (AW + 1)'(pop);

	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem[wr_ptr_reg] <= in_s.data;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wr_ptr_reg    <= '0;
			rd_ptr_reg    <= '0;
			count_reg     <= '0;
			not_full_reg  <= 1'b1;
			not_empty_reg <= 1'b0;
		end else begin
			wr_ptr_reg    <= wr_ptr_reg + AW'(push);
			rd_ptr_reg    <= rd_ptr_reg + AW'(pop);
			count_reg     <= count_next;
			not_full_reg  <= count_next != (AW + 1)'(DEPTH);
			not_empty_reg <= count_next != '0;
		end
	end
endmodule

// ===== rtl/ftx_scrambler.sv
`timescale 1ns/10ps
module ftx_scrambler (
	input  wire logic clk_sys,
	input  wire logic rst,
	input  wire logic bit_in,
	output logic      bit_out
);
	logic [ftx_pkg::SCR_LEN-1:0] lfsr_reg;
	logic                        key;
	logic [3:0]                  age_reg;

	// (R11) cipher key bit
	assign key     = lfsr_reg[ftx_pkg::SCR_TAP_A] ^ lfsr_reg[ftx_pkg::SCR_TAP_B];
	assign bit_out = bit_in ^ key;

	// (R17) nonzero seed
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			lfsr_reg <= ftx_pkg::SCR_SEED;
		end else begin
			lfsr_reg <= {lfsr_reg[ftx_pkg::SCR_LEN-2:0], key};
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			age_reg <= 4'h0;
		end else if (age_reg != 4'hF) begin
			age_reg <= age_reg + 4'h1;
		end
	end

	a_lfsr_nonzero: assert property (@(posedge clk_sys) disable iff (rst) // (R17)
		lfsr_reg != '0)
		else $error("scrambler state reached zero");

	a_cipher_law: assert property (@(posedge clk_sys) disable iff (rst) // (R11)
		(age_reg > 4'hB) |-> lfsr_reg[0] == ($past(lfsr_reg[0], 11) ^ $past(lfsr_reg[0], 9)))
		else $error("scrambler sequence breaks its recurrence");
endmodule

// ===== rtl/ftx_tx_pcs.sv
`timescale 1ns/10ps
// Overview of operation
// (R1) every mac nibble goes to the coder unfiltered
// (R2) data nibbles map to their standard five-bit code groups
// (R3) idle code group fills the line between frames
// (R4) start delimiter is J then K
// (R5) first preamble byte becomes the J K pair
// (R6) end delimiter is T then R
// (R7) T R follows the last data group when enable drops, then idle
// (R8) flow-control code group is never sent for data
// (R9) preamble, sfd, payload and crc nibbles coded alike
// (R10) each code group passes through the scrambler to the mlt-3 stage
// (R11) eleven-bit stream cipher, x[n] = x[n-11] xor x[n-9]
// (R12) code groups serialised as one continuous bit stream
// (R13) a zero bit keeps the line level
// (R14) a one bit steps through negative, zero, positive, zero
// (R15) nibble strobe derived from the internal symbol clock
// (R16) invalid code groups are never sent
// (R17) scrambler seeded nonzero at reset
module ftx_tx_pcs #(
	parameter int unsigned DEPTH = ftx_pkg::FIFO_DEPTH
) (
	input  wire logic       clk_sys,
	input  wire logic       rst,
	input  wire logic [3:0] mii_txd,
	input  wire logic       mii_tx_en,
	output logic            mii_tx_stb,
	output logic            mii_tx_ready,
	output logic            tx_active,
	output logic            line_bit,
	output logic            mlt_pos,
	output logic            mlt_neg
);
	// ****************************************
	// declarations
	// ****************************************
	ftx_stream_if #(.WIDTH(ftx_pkg::FIFO_W)) fifo_in ();
	ftx_stream_if #(.WIDTH(ftx_pkg::FIFO_W)) fifo_out ();

	logic [2:0]            bit_cnt_reg;
	logic                  sym_load;
	logic                  stb_reg;
	logic                  en_prev_reg;
	ftx_pkg::ftx_state_type state_reg;
	ftx_pkg::ftx_state_type state_next;
	ftx_pkg::ftx_code_type code_next;
	ftx_pkg::ftx_code_type shreg_reg;
	logic                  pop;
	logic                  head_valid;
	logic                  head_en;
	logic [3:0]            head_nib;
	logic                  scr_bit;
	logic                  line_bit_reg;
	logic [1:0]            mlt_phase_reg;
	logic [1:0]            mlt_phase_next;
	logic                  mlt_pos_reg;
	logic                  mlt_neg_reg;
	logic                  tx_active_reg;

	if (ftx_pkg::SYM_BITS != 5) begin : g_bad_rate
		$error("symbol length must be five bits");
	end

	// ****************************************
	// symbol timing
	// ****************************************
	// clk_sys stands in for the line bit clock, so one symbol is five edges;
	// the true 125 Mbps figure holds only when this clock runs at that rate
	// (R12) continuous bit slots
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			bit_cnt_reg <= ftx_pkg::BIT_CNT_RST;
		end else if (bit_cnt_reg == ftx_pkg::BIT_CNT_LAST) begin
			bit_cnt_reg <= ftx_pkg::BIT_CNT_RST;
		end else begin
			bit_cnt_reg <= bit_cnt_reg + 3'h1;
		end
	end

	assign sym_load = bit_cnt_reg == ftx_pkg::BIT_CNT_LAST;

	// (R15) nibble strobe per symbol
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			stb_reg <= 1'b0;
		end else begin
			stb_reg <= bit_cnt_reg == ftx_pkg::STB_PHASE;
		end
	end

	assign mii_tx_stb = stb_reg;

	// ****************************************
	// nibble intake
	// ****************************************
	// the mac sits on this clock, so its outputs need no synchroniser
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			en_prev_reg <= 1'b0;
		end else if (stb_reg) begin
			en_prev_reg <= mii_tx_en;
		end
	end

	// (R1) forward nibbles unfiltered
	// one extra word with enable low marks the frame end for the coder
	assign fifo_in.valid = stb_reg && (mii_tx_en || en_prev_reg);
	assign fifo_in.data  = {mii_tx_en, mii_txd};
	assign mii_tx_ready  = fifo_in.ready;

	ftx_fifo #(
		.WIDTH (ftx_pkg::FIFO_W),
		.DEPTH (DEPTH)
	) u_fifo (
		.clk_sys (clk_sys),
		.rst     (rst),
		.in_s    (fifo_in),
		.out_s   (fifo_out)
	);

	assign head_valid = fifo_out.valid;
	assign head_en    = fifo_out.data[ftx_pkg::NIB_BITS];
	assign head_nib   = fifo_out.data[ftx_pkg::NIB_BITS-1:0];

	// ****************************************
	// framing and 4b/5b coding
	// ****************************************
	// (R9) no field interpretation
	always_comb begin
		state_next = state_reg;
		code_next  = ftx_pkg::CODE_I;
		pop        = 1'b0;
		// (R8) (R16) legal groups only
		// every branch picks idle, a delimiter or a table entry, never 10000
		unique case (state_reg)
			ftx_pkg::ST_IDLE: begin
				// (R3) idle between frames
				if (head_valid) begin
					pop = 1'b1;
					// (R5) first preamble nibble replaced
					if (head_en) begin
						code_next  = ftx_pkg::CODE_J;
						state_next = ftx_pkg::ST_K;
					end
				end
			end
			ftx_pkg::ST_K: begin
				// (R4) second delimiter group
				code_next  = ftx_pkg::CODE_K;
				state_next = ftx_pkg::ST_DATA;
				if (head_valid && head_en) begin
					pop = 1'b1;
				end
			end
			ftx_pkg::ST_DATA: begin
				if (head_valid && head_en) begin
					pop = 1'b1;
					// (R2) data lookup
					code_next = ftx_pkg::enc_4b5b(head_nib);
				end else begin
					// (R7) frame end appends T
					// an underrun also ends the frame rather than sending junk
					pop        = head_valid;
					code_next  = ftx_pkg::CODE_T;
					state_next = ftx_pkg::ST_R;
				end
			end
			ftx_pkg::ST_R: begin
				// (R6) closing R group
				code_next  = ftx_pkg::CODE_R;
				state_next = ftx_pkg::ST_IDLE;
			end
		endcase
	end

	assign fifo_out.ready = pop && sym_load;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_reg <= ftx_pkg::ST_IDLE;
		end else if (sym_load) begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			tx_active_reg <= 1'b0;
		end else if (sym_load) begin
			tx_active_reg <= state_next != ftx_pkg::ST_IDLE;
		end
	end

	assign tx_active = tx_active_reg;

	// ****************************************
	// serialiser and scrambler
	// ****************************************
	// (R12) shift out msb first
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			shreg_reg <= ftx_pkg::CODE_I;
		end else if (sym_load) begin
			shreg_reg <= code_next;
		end else begin
			shreg_reg <= {shreg_reg[3:0], 1'b0};
		end
	end

	// (R10) code bits through scrambler
	ftx_scrambler u_scr (
		.clk_sys (clk_sys),
		.rst     (rst),
		.bit_in  (shreg_reg[4]),
		.bit_out (scr_bit)
	);

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			line_bit_reg <= 1'b0;
		end else begin
			line_bit_reg <= scr_bit;
		end
	end

	assign line_bit = line_bit_reg;

	// ****************************************
	// mlt-3 levels
	// ****************************************
	// (R13) (R14) hold or step
	assign mlt_phase_next = scr_bit ? mlt_phase_reg + 2'h1 : mlt_phase_reg;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			mlt_phase_reg <= ftx_pkg::MLT_RST;
			mlt_pos_reg   <= 1'b0;
			mlt_neg_reg   <= 1'b0;
		end else begin
			mlt_phase_reg <= mlt_phase_next;
			mlt_pos_reg   <= mlt_phase_next == ftx_pkg::MLT_POS;
			mlt_neg_reg   <= mlt_phase_next == ftx_pkg::MLT_NEG;
		end
	end

	assign mlt_pos = mlt_pos_reg;
	assign mlt_neg = mlt_neg_reg;

	// ****************************************
	// checks
	// ****************************************
	a_idle_fill: assert property (@(posedge clk_sys) disable iff (rst) // (R3)
		(sym_load && state_reg == ftx_pkg::ST_IDLE && !(head_valid && head_en))
		|=> shreg_reg == ftx_pkg::CODE_I)
		else $error("idle group missing between frames");

	a_start_pair: assert property (@(posedge clk_sys) disable iff (rst) // (R4)
		(sym_load && state_reg == ftx_pkg::ST_IDLE && head_valid && head_en)
		|=> shreg_reg == ftx_pkg::CODE_J ##5 shreg_reg == ftx_pkg::CODE_K)
		else $error("start delimiter pair wrong");

	a_preamble_swap: assert property (@(posedge clk_sys) disable iff (rst) // (R5)
		(sym_load && state_reg == ftx_pkg::ST_K && head_valid && head_en)
		|-> fifo_out.ready)
		else $error("second preamble nibble not consumed by the delimiter");

	a_end_pair: assert property (@(posedge clk_sys) disable iff (rst) // (R7)
		(sym_load && state_reg == ftx_pkg::ST_DATA && !(head_valid && head_en))
		|=> shreg_reg == ftx_pkg::CODE_T ##5 shreg_reg == ftx_pkg::CODE_R
		##4 state_reg == ftx_pkg::ST_IDLE)
		else $error("end delimiter pair wrong");

	a_data_map: assert property (@(posedge clk_sys) disable iff (rst) // (R2)
		(sym_load && state_reg == ftx_pkg::ST_DATA && head_valid && head_en)
		|=> shreg_reg == ftx_pkg::enc_4b5b($past(head_nib)))
		else $error("data nibble coded wrongly");

	a_no_bad_code: assert property (@(posedge clk_sys) disable iff (rst) // (R16)
		sym_load |=> ftx_pkg::code_legal(shreg_reg))
		else $error("invalid code group sent");

	a_no_fc_code: assert property (@(posedge clk_sys) disable iff (rst) // (R8)
		sym_load |=> shreg_reg != ftx_pkg::CODE_FC)
		else $error("flow-control group sent");

	a_nibble_taken: assert property (@(posedge clk_sys) disable iff (rst) // (R1)
		(stb_reg && mii_tx_en && mii_tx_ready)
		|=> fifo_out.valid
		&& u_fifo.mem[$past(u_fifo.wr_ptr_reg)] == {1'b1, $past(mii_txd)})
		else $error("mac nibble dropped");

	a_symbol_rate: assert property (@(posedge clk_sys) disable iff (rst) // (R12)
		sym_load |=> !sym_load [*4] ##1 sym_load)
		else $error("symbol slots not five bits apart");

	a_strobe_rate: assert property (@(posedge clk_sys) disable iff (rst) // (R15)
		stb_reg |=> !stb_reg [*4] ##1 stb_reg)
		else $error("nibble strobe not once per symbol");

	a_mlt3_hold: assert property (@(posedge clk_sys) disable iff (rst) // (R13)
		!line_bit_reg |-> $stable({mlt_pos_reg, mlt_neg_reg}))
		else $error("line level moved on a zero bit");

	a_mlt3_step: assert property (@(posedge clk_sys) disable iff (rst) // (R14)
		line_bit_reg |-> mlt_phase_reg == 2'($past(mlt_phase_reg) + 2'h1)
		&& !(mlt_pos_reg && mlt_neg_reg))
		else $error("line level did not step on a one bit");

	a_mlt3_levels: assert property (@(posedge clk_sys) disable iff (rst) // (R14)
		!(mlt_pos_reg && mlt_neg_reg))
		else $error("line driven positive and negative at once");

	// the cipher state after an edge holds the key that bit was combined with
	a_scramble_path: assert property (@(posedge clk_sys) disable iff (rst) // (R10)
		line_bit_reg == ($past(shreg_reg[4]) ^ u_scr.lfsr_reg[0]))
		else $error("line bit is not the code bit under the cipher key");

	a_tail_group: assert property (@(posedge clk_sys) disable iff (rst) // (R6)
		(sym_load && state_reg == ftx_pkg::ST_R)
		|=> shreg_reg == ftx_pkg::CODE_R)
		else $error("closing group of the end delimiter wrong");

	a_frame_close: assert property (@(posedge clk_sys) disable iff (rst) // (R7)
		(sym_load && state_reg == ftx_pkg::ST_R)
		|=> !tx_active_reg)
		else $error("frame flag still up after the end delimiter");

	a_field_blind: assert property (@(posedge clk_sys) disable iff (rst) // (R9)
		(sym_load && state_reg == ftx_pkg::ST_DATA && head_valid && head_en)
		|-> fifo_out.ready)
		else $error("frame nibble held back by the coder");

	a_no_gating: assert property (@(posedge clk_sys) disable iff (rst) // (R1)
		(stb_reg && mii_tx_en) |-> fifo_in.valid)
		else $error("enabled nibble not offered to the buffer");

	a_strobe_lead: assert property (@(posedge clk_sys) disable iff (rst) // (R15)
		stb_reg |=> sym_load)
		else $error("nibble strobe not one cycle before the symbol load");

	// no disable here: this one watches the reset itself
	a_reset_quiet: assert property (@(posedge clk_sys) // (R3)
		rst |=> !stb_reg && !tx_active_reg && state_reg == ftx_pkg::ST_IDLE)
		else $error("coder not idle after reset");
endmodule

// ===== verification/ftx_mac_model.sv
`timescale 1ns/10ps
// ****************************************
// mac transmit side
// ****************************************
module ftx_mac_model (
	input  wire logic       clk_sys,
	input  wire logic       mii_tx_stb,
	output logic      [3:0] mii_txd,
	output logic            mii_tx_en
);
	initial begin
		mii_txd = 4'h0;
		mii_tx_en = 1'b0;
	end

	// returns just after the edge that opens a strobe cycle
	task automatic wait_slot();
		do begin
			@(posedge clk_sys);
			#1;
		end while (mii_tx_stb !== 1'b1);
	endtask

	// one nibble per strobe, then one strobe with enable low
	task automatic send(input logic [3:0] nibs [$]);
		foreach (nibs[i]) begin
			wait_slot();
			mii_txd = nibs[i];
			mii_tx_en = 1'b1;
		end
		wait_slot();
		// released data shows the inverse so a stale nibble cannot pass
		mii_txd = ~mii_txd;
		mii_tx_en = 1'b0;
	endtask
endmodule

// ===== verification/ftx_tx_pcs_tb_top.sv
`timescale 1ns/10ps
`define FTX_CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fails++; $display("unexpected at %0t: got %h expected %h", $time, (g), (e)); end end
module ftx_tx_pcs_tb_top;
	logic        clk_sys;
	logic        rst;
	logic  [3:0] mii_txd;
	logic        mii_tx_en;
	logic        mii_tx_stb;
	logic        mii_tx_ready;
	logic        tx_active;
	logic        line_bit;
	logic        mlt_pos;
	logic        mlt_neg;
	int          fails = 0;
	int          samples_checked = 0;
	int          cnt;
	int          gap;
	int          ph;
	bit          seen;
	logic  [1:0] mlt_ph;
	logic [10:0] hist;
	logic        key;
	logic  [4:0] sh;
	logic  [4:0] groups [$];
	// own copy of the data code table, kept apart from the design package
	localparam logic [4:0] ENC [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E,
		5'h0F, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};

	ftx_tx_pcs #(.DEPTH(8)) ftx_tx_pcs_inst (
		.clk_sys(clk_sys), .rst(rst), .mii_txd(mii_txd), .mii_tx_en(mii_tx_en),
		.mii_tx_stb(mii_tx_stb), .mii_tx_ready(mii_tx_ready), .tx_active(tx_active),
		.line_bit(line_bit), .mlt_pos(mlt_pos), .mlt_neg(mlt_neg)
	);
	ftx_mac_model ftx_mac_model_inst (
		.clk_sys(clk_sys), .mii_tx_stb(mii_tx_stb), .mii_txd(mii_txd), .mii_tx_en(mii_tx_en)
	);

	initial clk_sys = 1'b0;
	always #10 clk_sys = ~clk_sys;

	// ****************************************
	// line monitor
	// ****************************************
	// keys are recovered from idle, then predicted from the cipher recurrence
	always @(negedge clk_sys) begin
		if (rst) begin
			cnt = 0;
			gap = 0;
			seen = 0;
			mlt_ph = 2'h1;
		end else begin
			cnt++;
			gap++;
			mlt_ph = mlt_ph + {1'b0, line_bit};
			`FTX_CHK({mlt_pos, mlt_neg}, {mlt_ph == 2'h2, mlt_ph == 2'h0})
			key = (cnt < 15) ? ~line_bit : hist[10] ^ hist[8];
			if (cnt >= 4)
				hist = {hist[9:0], key};
			if (cnt == 15)
				`FTX_CHK(hist != 11'h0, 1'b1)
			sh = {sh[3:0], line_bit ^ key};
			if (mii_tx_stb === 1'b1) begin
				if (seen)
					`FTX_CHK(gap, 5)
				`FTX_CHK(mii_tx_ready, 1'b1)
				gap = 0;
				seen = 1;
				ph = 0;
			end else begin
				ph = (ph == 4) ? 0 : ph + 1;
			end
			if (cnt >= 15 && seen && ph == 2)
				groups.push_back(sh);
		end
	end

	// ****************************************
	// shared tasks
	// ****************************************
	task automatic drain();
		int n;
		n = 0;
		while (tx_active !== 1'b0 && n < 200) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		`FTX_CHK(tx_active, 1'b0)
		repeat (20) @(posedge clk_sys);
	endtask

	// leading idle groups are skipped; the frame must be followed by idle
	task automatic expect_groups(input logic [4:0] exp [$]);
		int i;
		i = 0;
		while (i < groups.size() && groups[i] === ftx_pkg::CODE_I)
			i++;
		foreach (exp[k])
			`FTX_CHK(groups[i + k], exp[k])
		`FTX_CHK(groups[i + exp.size()], ftx_pkg::CODE_I)
		groups.delete();
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_idle();
		repeat (60) @(posedge clk_sys);
		#1;
		foreach (groups[k])
			`FTX_CHK(groups[k], ftx_pkg::CODE_I)
		`FTX_CHK(tx_active, 1'b0)
		groups.delete();
	endtask

	// two preamble bytes, a delimiter nibble, then every data value
	task automatic t_frame();
		logic [3:0] nibs [$];
		logic [4:0] exp [$];
		nibs = {4'h5, 4'h5, 4'h5, 4'h5, 4'hD};
		exp = {ftx_pkg::CODE_J, ftx_pkg::CODE_K, ENC[5], ENC[5], ENC[13]};
		for (int v = 0; v < 16; v++) begin
			nibs.push_back(4'(v));
			exp.push_back(ENC[v]);
		end
		exp.push_back(ftx_pkg::CODE_T);
		exp.push_back(ftx_pkg::CODE_R);
		ftx_mac_model_inst.send(nibs);
		`FTX_CHK(tx_active, 1'b1)
		drain();
		expect_groups(exp);
	endtask

	task automatic t_short();
		logic [3:0] nibs [$];
		nibs = {4'h5};
		ftx_mac_model_inst.send(nibs);
		drain();
		expect_groups({ftx_pkg::CODE_J, ftx_pkg::CODE_K, ftx_pkg::CODE_T, ftx_pkg::CODE_R});
	endtask

	// one enable-low slot between frames: T R directly before the next J K
	task automatic t_b2b();
		logic [3:0] nibs [$];
		logic [4:0] exp [$];
		nibs = {4'h5, 4'h5, 4'hA, 4'h3};
		ftx_mac_model_inst.send(nibs);
		nibs = {4'h5, 4'h5, 4'hC};
		ftx_mac_model_inst.send(nibs);
		drain();
		exp = {ftx_pkg::CODE_J, ftx_pkg::CODE_K, ENC[10], ENC[3], ftx_pkg::CODE_T,
			ftx_pkg::CODE_R, ftx_pkg::CODE_J, ftx_pkg::CODE_K, ENC[12], ftx_pkg::CODE_T,
			ftx_pkg::CODE_R};
		expect_groups(exp);
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial begin
		rst = 1'b1;
		repeat (3) @(posedge clk_sys);
		#1;
		rst = 1'b0;
		t_idle();
		t_frame();
		t_short();
		t_b2b();
		complete_run();
	end

	// the whole run needs about 300 cycles
	initial begin
		#200000;
		fails++;
		complete_run();
	end
endmodule
